// ==== include/ucs_pkg.sv ====
package ucs_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_RXCMD = 8'h0C;
	localparam logic [7:0] OFF_MODE = 8'h10;
	// CTRL fields
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP_LSB = 1;
	// CMD fields
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_WDATA_LSB = 8;
	localparam int CMD_PID_LSB = 16;
	// STATUS fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ABORT = 2;
	localparam int ST_RXNEW = 3;
	localparam int ST_ALT = 4;
	localparam int ST_RDATA_LSB = 8;
	// MODE fields
	localparam int MODE_HOST = 0;
	localparam int MODE_XCVR_LSB = 1;
	localparam int MODE_TERM = 3;
	localparam int MODE_OPM_LSB = 4;
	// Reset values
	localparam logic [31:0] CMD_RST = 32'h0000_0000;
	localparam logic [5:0] MODE_RST = 6'h00;
	// Operations
	localparam logic [2:0] OP_WR_IMM = 3'h0;
	localparam logic [2:0] OP_WR_EXT = 3'h1;
	localparam logic [2:0] OP_RD_IMM = 3'h2;
	localparam logic [2:0] OP_RD_EXT = 3'h3;
	localparam logic [2:0] OP_TX_PID = 3'h4;
	localparam logic [2:0] OP_TX_NOPID = 3'h5;
	// Command byte
	localparam logic [7:0] NOOP = 8'h00;
	localparam logic [1:0] TYPE_SPECIAL = 2'h0;
	localparam logic [1:0] TYPE_TX = 2'h1;
	localparam logic [1:0] TYPE_WR = 2'h2;
	localparam logic [1:0] TYPE_RD = 2'h3;
	localparam logic [5:0] EXT_ADDR = 6'h3F;
	// Status byte fields
	localparam int RX_LS_LSB = 0;
	localparam int RX_VB_LSB = 2;
	localparam int RX_EV_LSB = 4;
	localparam int RX_ID = 6;
	localparam int RX_ALT = 7;
	// Decoded line meaning
	localparam logic [3:0] LM_SE0 = 4'h0;
	localparam logic [3:0] LM_J = 4'h1;
	localparam logic [3:0] LM_K = 4'h2;
	localparam logic [3:0] LM_SE1 = 4'h3;
	localparam logic [3:0] LM_SQUELCH = 4'h4;
	localparam logic [3:0] LM_NOSQ = 4'h5;
	localparam logic [3:0] LM_CHIRP_HI = 4'h6;
	localparam logic [3:0] LM_CHIRP_LO = 4'h7;
	localparam logic [3:0] LM_INVALID = 4'h8;
	localparam logic [1:0] XCVR_HS = 2'h0;
	localparam logic [1:0] XCVR_LS = 2'h2;
	localparam logic [1:0] OPM_CHIRP = 2'h2;
	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_STOP, ST_TURN,
		ST_RDATA} ucs_state_e;
endpackage : ucs_pkg

// ==== rtl/ucs_link_ctrl.sv ====
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module ucs_link_ctrl #(
	parameter int APB_AW = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ulpi_dir,
	input wire logic ulpi_nxt,
	input wire logic [7:0] ulpi_data_in,
	output logic [7:0] ulpi_data_out,
	output logic ulpi_data_oe_n,
	output logic ulpi_stp
);
	function automatic logic [3:0] ucs_line_decode(input logic host, input logic [1:0] xcvr,
		input logic term, input logic [1:0] opm, input logic [1:0] ls);
		logic chirp;
		chirp = host ? (!term && opm == ucs_pkg::OPM_CHIRP) : term;
		if (xcvr == ucs_pkg::XCVR_HS) begin
			if (ls == 2'h0)
				return ucs_pkg::LM_SQUELCH;
			if (ls == 2'h3 || (ls == 2'h2 && !chirp))
				return ucs_pkg::LM_INVALID;
			if (!chirp)
				return ucs_pkg::LM_NOSQ;
			return (ls == 2'h1) ? ucs_pkg::LM_CHIRP_HI : ucs_pkg::LM_CHIRP_LO;
		end
		if (host && xcvr == ucs_pkg::XCVR_LS && ls == 2'h1)
			return ucs_pkg::LM_K;
		if (host && xcvr == ucs_pkg::XCVR_LS && ls == 2'h2)
			return ucs_pkg::LM_J;
		return {2'h0, ls};
	endfunction : ucs_line_decode

	function automatic logic ucs_legal_cmd(input logic [7:0] b);
		return b[7:6] != ucs_pkg::TYPE_SPECIAL && (b[7:6] != ucs_pkg::TYPE_TX || b[5:4] == 2'h0);
	endfunction : ucs_legal_cmd

	ucs_pkg::ucs_state_e state_reg, state_next;
	logic [1:0] dir_sync_reg, nxt_sync_reg;
	logic [15:0] data_sync_reg;
	logic dir_q_reg;
	// Held off until synced DIR is first seen low: the pipe resets to DIR high
	logic armed_reg;
	logic [31:0] cmd_reg;
	logic [5:0] mode_reg;
	logic [2:0] op_reg;
	logic start_reg, done_reg, abort_reg, rxnew_reg, alt_reg;
	logic [7:0] rdata_reg, rxcmd_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	logic [7:0] data_out_reg;
	logic oe_n_reg, stp_reg;

	// Pins pass two flops; the first stage feeds only the second
	wire dir_s = dir_sync_reg[1];
	wire nxt_s = nxt_sync_reg[1];
	wire [7:0] data_s = data_sync_reg[15:8];

	wire acc = psel && penable && !pready_reg;
	wire wr = acc && pwrite;
	wire [7:0] off = 8'(paddr);
	wire hit = off == ucs_pkg::OFF_CTRL || off == ucs_pkg::OFF_CMD
		|| off == ucs_pkg::OFF_STATUS || off == ucs_pkg::OFF_RXCMD || off == ucs_pkg::OFF_MODE;
	wire wr_ctrl = wr && off == ucs_pkg::OFF_CTRL;
	wire wr_status = wr && off == ucs_pkg::OFF_STATUS;
	wire busy = state_reg != ucs_pkg::ST_IDLE;
	wire go = wr_ctrl && pwdata[ucs_pkg::CTRL_GO] && !busy && !start_reg;

	wire [7:0] reg_addr = cmd_reg[ucs_pkg::CMD_ADDR_LSB +: 8];
	wire [7:0] wdata = cmd_reg[ucs_pkg::CMD_WDATA_LSB +: 8];
	wire [3:0] pid = cmd_reg[ucs_pkg::CMD_PID_LSB +: 4];
	wire is_wr = op_reg == ucs_pkg::OP_WR_IMM || op_reg == ucs_pkg::OP_WR_EXT;
	wire is_rd = op_reg == ucs_pkg::OP_RD_IMM || op_reg == ucs_pkg::OP_RD_EXT;
	wire is_pid = op_reg == ucs_pkg::OP_TX_PID;
	// Immediate address 3F collides with the extended code, so it goes extended
	wire is_ext = op_reg == ucs_pkg::OP_WR_EXT || op_reg == ucs_pkg::OP_RD_EXT
		|| ((is_wr || is_rd) && reg_addr[5:0] == ucs_pkg::EXT_ADDR);
	wire [7:0] ext_byte = (op_reg == ucs_pkg::OP_WR_IMM || op_reg == ucs_pkg::OP_RD_IMM)
		? {2'h0, reg_addr[5:0]} : reg_addr;
	wire [1:0] cmd_type = is_wr ? ucs_pkg::TYPE_WR : (is_rd ? ucs_pkg::TYPE_RD : ucs_pkg::TYPE_TX);
	wire [5:0] cmd_low = is_ext ? ucs_pkg::EXT_ADDR
		: ((is_wr || is_rd) ? reg_addr[5:0] : (is_pid ? {2'h0, pid} : 6'h00));
	wire [7:0] cmd_byte = {cmd_type, cmd_low};

	// Status byte is any bus-owned byte outside turnaround with NXT low, other than the register read data byte in ST_RDATA
	wire rx_take = dir_s && dir_q_reg && armed_reg && !nxt_s
		&& state_reg != ucs_pkg::ST_RDATA;
	wire rd_take = state_reg == ucs_pkg::ST_RDATA && dir_s && !nxt_s;
	wire lost = dir_s && (state_reg == ucs_pkg::ST_CMD || state_reg == ucs_pkg::ST_ADDR
		|| state_reg == ucs_pkg::ST_DATA || (state_reg == ucs_pkg::ST_RDATA && nxt_s)
		|| (state_reg == ucs_pkg::ST_TURN && nxt_s));
	wire finish = state_reg == ucs_pkg::ST_STOP || rd_take;
	wire [3:0] line_mean = ucs_line_decode(mode_reg[ucs_pkg::MODE_HOST],
		mode_reg[ucs_pkg::MODE_XCVR_LSB +: 2], mode_reg[ucs_pkg::MODE_TERM],
		mode_reg[ucs_pkg::MODE_OPM_LSB +: 2], rxcmd_reg[ucs_pkg::RX_LS_LSB +: 2]);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ucs_pkg::ST_IDLE: if (start_reg && !dir_s) state_next = ucs_pkg::ST_CMD;
			ucs_pkg::ST_CMD: begin
				if (dir_s)
					state_next = ucs_pkg::ST_IDLE;
				else if (nxt_s)
					state_next = is_ext ? ucs_pkg::ST_ADDR : (is_rd ? ucs_pkg::ST_TURN
						: (is_pid ? ucs_pkg::ST_STOP : ucs_pkg::ST_DATA));
			end
			ucs_pkg::ST_ADDR: begin
				if (dir_s)
					state_next = ucs_pkg::ST_IDLE;
				else if (nxt_s)
					state_next = is_rd ? ucs_pkg::ST_TURN : ucs_pkg::ST_DATA;
			end
			ucs_pkg::ST_DATA: begin
				if (dir_s)
					state_next = ucs_pkg::ST_IDLE;
				else if (nxt_s)
					state_next = ucs_pkg::ST_STOP;
			end
			ucs_pkg::ST_STOP: state_next = ucs_pkg::ST_IDLE;
			ucs_pkg::ST_TURN: begin
				if (lost)
					state_next = ucs_pkg::ST_IDLE;
				else if (dir_s)
					state_next = ucs_pkg::ST_RDATA;
			end
			ucs_pkg::ST_RDATA: if (dir_s) state_next = ucs_pkg::ST_IDLE;
			default: state_next = ucs_pkg::ST_IDLE;
		endcase
	end

	wire [7:0] drive_next = (state_next == ucs_pkg::ST_CMD) ? cmd_byte
		: (state_next == ucs_pkg::ST_ADDR) ? ext_byte
		: (state_next == ucs_pkg::ST_DATA) ? wdata : ucs_pkg::NOOP;

	wire [31:0] status_word = {16'h0, rdata_reg, 3'h0, alt_reg, rxnew_reg, abort_reg, done_reg,
		busy | start_reg};
	wire [31:0] rd_mux = (off == ucs_pkg::OFF_CTRL) ? {28'h0, op_reg, start_reg}
		: (off == ucs_pkg::OFF_CMD) ? cmd_reg
		: (off == ucs_pkg::OFF_STATUS) ? status_word
		: (off == ucs_pkg::OFF_RXCMD) ? {20'h0, line_mean, rxcmd_reg}
		: (off == ucs_pkg::OFF_MODE) ? {26'h0, mode_reg} : 32'h0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_sync_reg <= 2'h3;
			nxt_sync_reg <= 2'h0;
			data_sync_reg <= 16'h0000;
			dir_q_reg <= 1'b1;
			armed_reg <= 1'b0;
		end else begin
			dir_sync_reg <= {dir_sync_reg[0], ulpi_dir};
			nxt_sync_reg <= {nxt_sync_reg[0], ulpi_nxt};
			data_sync_reg <= {data_sync_reg[7:0], ulpi_data_in};
			dir_q_reg <= dir_s;
			armed_reg <= armed_reg | !dir_s;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ucs_pkg::ST_IDLE;
			data_out_reg <= ucs_pkg::NOOP;
			oe_n_reg <= 1'b1;
			stp_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			data_out_reg <= drive_next;
			oe_n_reg <= dir_s;
			stp_reg <= state_next == ucs_pkg::ST_STOP;
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg <= ucs_pkg::CMD_RST;
			mode_reg <= ucs_pkg::MODE_RST;
			op_reg <= ucs_pkg::OP_WR_IMM;
			start_reg <= 1'b0;
			done_reg <= 1'b0;
			abort_reg <= 1'b0;
			rxnew_reg <= 1'b0;
			alt_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rxcmd_reg <= 8'h00;
		end else begin
			if (wr && off == ucs_pkg::OFF_CMD && !busy && !start_reg)
				cmd_reg <= pwdata;
			if (wr && off == ucs_pkg::OFF_MODE)
				mode_reg <= pwdata[5:0];
			if (go)
				op_reg <= pwdata[ucs_pkg::CTRL_OP_LSB +: 3];
			start_reg <= go | (start_reg && state_next == ucs_pkg::ST_IDLE);
			done_reg <= finish | (done_reg && !(wr_status && pwdata[ucs_pkg::ST_DONE]));
			abort_reg <= lost | (abort_reg && !(wr_status && pwdata[ucs_pkg::ST_ABORT]));
			rxnew_reg <= rx_take | (rxnew_reg && !(wr_status && pwdata[ucs_pkg::ST_RXNEW]));
			alt_reg <= (rx_take && data_s[ucs_pkg::RX_ALT])
				| (alt_reg && !(wr_status && pwdata[ucs_pkg::ST_ALT]));
			if (rd_take)
				rdata_reg <= data_s;
			if (rx_take)
				rxcmd_reg <= data_s;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= 32'h0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= acc;
			pslverr_reg <= acc && !hit;
			prdata_reg <= (acc && !pwrite) ? rd_mux : 32'h0;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign ulpi_data_out = data_out_reg;
	assign ulpi_data_oe_n = oe_n_reg;
	assign ulpi_stp = stp_reg;

	sequence cmd_taken_s;
		state_reg == ucs_pkg::ST_CMD && nxt_s && !dir_s;
	endsequence
	sequence ext_cmd_s;
		state_reg == ucs_pkg::ST_CMD && data_out_reg[5:0] == ucs_pkg::EXT_ADDR
			&& data_out_reg[7];
	endsequence

	idle_bus_noop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(stp_reg) |-> data_out_reg == ucs_pkg::NOOP && state_reg == ucs_pkg::ST_IDLE)
		else $error("bus not idle after stop");
	cmd_held_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == ucs_pkg::ST_CMD && !nxt_s && !dir_s |=> state_reg == ucs_pkg::ST_CMD
		&& $stable(data_out_reg) && data_out_reg != ucs_pkg::NOOP)
		else $error("command byte not held");
	byte_held_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ucs_pkg::ST_ADDR || state_reg == ucs_pkg::ST_DATA) && !nxt_s && !dir_s
		|=> $stable(state_reg) && $stable(data_out_reg))
		else $error("address or data byte not held");
	legal_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == ucs_pkg::ST_CMD |-> ucs_legal_cmd(data_out_reg))
		else $error("illegal command byte");
	pid_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_taken_s ##0 is_pid |-> data_out_reg == {ucs_pkg::TYPE_TX, 2'h0, pid}
		##1 stp_reg)
		else $error("bad packet identifier transmit");
	ext_addr_next_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ext_cmd_s ##0 cmd_taken_s |=> state_reg == ucs_pkg::ST_ADDR && data_out_reg == ext_byte)
		else $error("extended address not sent");
	imm_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == ucs_pkg::ST_CMD && data_out_reg[7] && data_out_reg[5:0] != ucs_pkg::EXT_ADDR
		|-> data_out_reg[5:0] == reg_addr[5:0] && !is_ext)
		else $error("immediate address wrong");
	type_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == ucs_pkg::ST_CMD |-> data_out_reg[7:6] == (is_wr ? 2'h2 : (is_rd ? 2'h3 : 2'h1)))
		else $error("command type bits wrong");
	rx_accept_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rx_take |=> rxcmd_reg == $past(data_s) && rxnew_reg)
		else $error("status byte dropped");
	host_ls_role_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_reg[ucs_pkg::MODE_HOST] && mode_reg[2:1] == ucs_pkg::XCVR_LS
		&& rxcmd_reg[1:0] == 2'h1 |-> line_mean == ucs_pkg::LM_K)
		else $error("host low speed decode wrong");
endmodule : ucs_link_ctrl

// ==== tb/ucs_phy_model.sv ====
`timescale 1ns/1ps
// Behavioural transceiver: takes command bytes, serves register reads, reports status bytes
module ucs_phy_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] ulpi_data_out,
	input wire logic ulpi_data_oe_n,
	input wire logic ulpi_stp,
	input wire logic [7:0] st_in,
	output logic ulpi_dir,
	output logic ulpi_nxt,
	output logic [7:0] ulpi_data_in
);
	logic [7:0] regs [256];
	logic [7:0] cmd, addr, txd, sent, rb;
	logic [2:0] gap, ph;
	logic [1:0] k;
	logic tx_go;
	int bad;
	wire [7:0] c = k == 2'h0 ? ulpi_data_out : cmd;
	wire take = !ulpi_dir && !ulpi_data_oe_n && !ulpi_stp && gap == 3'h0 && ph == 3'h0 &&
		(k != 2'h0 || ulpi_data_out != 8'h00);
	wire ext_addr = k == 2'h1 && c[7] && c[5:0] == 6'h3F;
	wire rd_end = c[7:6] == 2'h3 && (k == 2'h0 ? c[5:0] != 6'h3F : ext_addr);
	wire [7:0] ra = k == 2'h0 ? {2'h0, ulpi_data_out[5:0]} : ulpi_data_out;
	// Released bus shows the inverse byte so stale data never looks valid
	assign ulpi_data_in = ulpi_dir ? rb : ~rb;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 256; i++)
				regs[i] <= 8'(i) ^ 8'h5A;
			{cmd, addr, txd, sent, rb} <= 40'h0;
			{gap, ph, k, tx_go, ulpi_dir, ulpi_nxt} <= 11'h000;
			bad <= 0;
		end else begin
			ulpi_nxt <= take;
			if (gap != 3'h0)
				gap <= gap - 3'h1;
			if (ulpi_stp && cmd[7:6] == 2'h2)
				regs[addr] <= txd;
			if (ulpi_stp)
				k <= 2'h0;
			if (take) begin
				// Byte spacing covers the link's two-flop input delay
				gap <= 3'h4;
				k <= rd_end ? 2'h0 : k + 2'h1;
				if (k == 2'h0) begin
					cmd <= ulpi_data_out;
					addr <= ra;
					tx_go <= 1'b0;
					bad <= bad + int'(ulpi_data_out[7:6] == 2'h0);
				end else if (ext_addr)
					addr <= ra;
				else begin
					txd <= ulpi_data_out;
					tx_go <= cmd[7:6] == 2'h1;
				end
				if (rd_end) begin
					rb <= regs[ra];
					ph <= 3'h3;
				end
			end else if (gap == 3'h0 && ph == 3'h0 && k == 2'h0 && ulpi_data_out == 8'h00 &&
				st_in != sent) begin
				rb <= st_in;
				sent <= st_in;
				ph <= 3'h3;
			end else if (gap == 3'h0 && ph != 3'h0) begin
				ph <= ph - 3'h1;
				ulpi_dir <= ph != 3'h1;
			end
		end
	end
endmodule : ucs_phy_model

// ==== tb/tb_ulpi_command_status_bytes.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_ulpi_command_status_bytes;
	logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, st_in = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv, lf = 32'h3E7C03C9;
	logic pready, pslverr, rerr, ulpi_dir, ulpi_nxt, ulpi_data_oe_n, ulpi_stp;
	logic [7:0] ulpi_data_in, ulpi_data_out, sh [256];
	logic [5:0] mtab [8] = '{6'h0A, 6'h0E, 6'h00, 6'h08, 6'h0D, 6'h0B, 6'h11, 6'h21};
	int miscompares = 0, check_count = 0, cyc = 0;
	always #12.5 sys_clk = ~sys_clk;
	ucs_link_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
		.ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out),
		.ulpi_data_oe_n(ulpi_data_oe_n), .ulpi_stp(ulpi_stp));
	ucs_phy_model m (.sys_clk(sys_clk), .rst_n(rst_n), .ulpi_data_out(ulpi_data_out),
		.ulpi_data_oe_n(ulpi_data_oe_n), .ulpi_stp(ulpi_stp), .st_in(st_in),
		.ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_in(ulpi_data_in));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	// Decoded line meaning for a mode {opmode, term, xcvr, host} and raw line state
	function automatic logic [3:0] exp_ls(input logic [5:0] md, input logic [1:0] ls);
		logic ch;
		ch = md[0] ? (!md[3] && md[5:4] == ucs_pkg::OPM_CHIRP) : md[3];
		if (md[2:1] == ucs_pkg::XCVR_HS && ch)
			return ls == 2'h0 ? 4'h4 : ls == 2'h3 ? 4'h8 : 4'h5 + ls;
		if (md[2:1] == ucs_pkg::XCVR_HS)
			return ls == 2'h0 ? 4'h4 : ls == 2'h1 ? 4'h5 : 4'h8;
		if (md[0] && md[2:1] == ucs_pkg::XCVR_LS)
			return {2'h0, ls[0], ls[1]};
		return {2'h0, ls};
	endfunction : exp_ls
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task wrap_up;
		$display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up;
		end
	end
	initial begin
		logic [2:0] op;
		logic [7:0] a, d, ea, ec, nb;
		logic [3:0] pid;
		logic [5:0] md;
		logic ext;
		for (int i = 0; i < 256; i++)
			sh[i] = 8'(i) ^ 8'h5A;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(ucs_pkg::OFF_CMD);
		`CHK(rdv, ucs_pkg::CMD_RST)
		rd(ucs_pkg::OFF_MODE);
		`CHK(rdv[5:0], ucs_pkg::MODE_RST)
		rd(8'h14);
		`CHK({rerr, rdv}, {1'b1, 32'h0})
		rd(ucs_pkg::OFF_STATUS);
		`CHK(rdv, 32'h0)
		$display("Test registers done");
		for (int i = 0; i < 24; i++) begin
			lf = nx(lf);
			op = 3'(i % 6);
			// First round uses address 3F, the extended-escape corner
			a = i < 6 ? 8'h3F : lf[7:0];
			d = lf[15:8];
			pid = lf[19:16] == 4'h0 ? 4'h1 : lf[19:16];
			ext = op == ucs_pkg::OP_WR_EXT || op == ucs_pkg::OP_RD_EXT;
			ea = ext ? a : {2'h0, a[5:0]};
			ec[7:6] = op < 3'h2 ? ucs_pkg::TYPE_WR : op < 3'h4 ? ucs_pkg::TYPE_RD : ucs_pkg::TYPE_TX;
			ec[5:0] = op == ucs_pkg::OP_TX_PID ? {2'h0, pid} : op == ucs_pkg::OP_TX_NOPID ? 6'h00 :
				ext ? ucs_pkg::EXT_ADDR : a[5:0];
			wr(ucs_pkg::OFF_CMD, {12'h0, pid, d, a});
			wr(ucs_pkg::OFF_CTRL, {28'h0, op, 1'b1});
			do rd(ucs_pkg::OFF_STATUS); while (rdv[ucs_pkg::ST_DONE] !== 1'b1);
			`CHK(rdv[ucs_pkg::ST_ABORT], 1'b0)
			`CHK(m.cmd, ec)
			if (op < 3'h2)
				sh[ea] = d;
			if (op < 3'h2)
				`CHK(m.regs[ea], d)
			if (op == ucs_pkg::OP_RD_IMM || op == ucs_pkg::OP_RD_EXT)
				`CHK(rdv[15:8], sh[ea])
			if (op == ucs_pkg::OP_TX_NOPID)
				`CHK({m.tx_go, m.txd}, {1'b1, d})
			`CHK(ulpi_data_out, 8'h00)
			`CHK({ulpi_data_oe_n, ulpi_stp}, 2'h0)
			`CHK(m.bad, 0)
			wr(ucs_pkg::OFF_STATUS, 32'h1E);
		end
		$display("Test commands done");
		for (int i = 0; i < 32; i++) begin
			md = mtab[i / 4];
			lf = nx(lf);
			nb = {lf[7:2], 2'(i % 4)};
			if (nb == st_in)
				nb[6] = ~nb[6];
			wr(ucs_pkg::OFF_MODE, {26'h0, md});
			wr(ucs_pkg::OFF_STATUS, 32'h1E);
			st_in <= nb;
			do rd(ucs_pkg::OFF_STATUS); while (rdv[ucs_pkg::ST_RXNEW] !== 1'b1);
			`CHK(rdv[ucs_pkg::ST_ALT], nb[7])
			rd(ucs_pkg::OFF_RXCMD);
			`CHK(rdv[7:0], nb)
			`CHK(rdv[11:8], exp_ls(md, nb[1:0]))
		end
		$display("Test status bytes done");
		wrap_up;
	end
endmodule : tb_ulpi_command_status_bytes
